// >>> hdl/modbus_pkg.sv
package modbus_pkg;

  // ----------------
  // function codes, addresses and answers
  // ----------------
  localparam logic [7:0] FC_RD_HOLD = 8'h03;
  localparam logic [7:0] FC_WR_COIL = 8'h05;
  localparam logic [7:0] FC_WR_REG = 8'h06;
  localparam logic [7:0] FC_WR_COILS = 8'h0F;
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILL_VAL = 8'h03;
  localparam logic [15:0] COIL_OFF = 16'h0000;
  localparam logic [15:0] COIL_ON = 16'hFF00;

  // ----------------
  // sizes and timing
  // ----------------
  localparam int MAX_FRAME = 256;
  localparam logic [15:0] MAX_READ_REGS = 16'h0032;
  localparam logic [8:0] SHORT_FRAME_LEN = 9'h006;
  localparam logic [8:0] COILS_HDR_LEN = 9'h007;
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESP_TIMEOUT_NS = 10000;
  localparam int RESP_TIMEOUT_CYC = RESP_TIMEOUT_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    K_ECHO = 2'h0,
    K_READ = 2'h1,
    K_EXC = 2'h2
  } rsp_kind_t;

  // state bytes needed for n packed contacts
  function automatic logic [15:0] coil_bytes(input logic [15:0] n);
    logic [16:0] s;
    s = {1'b0, n} + 17'h00007;
    return {2'b00, s[16:3]};
  endfunction

endpackage

// >>> hdl/modbus_link_if.sv
`timescale 1ns/1ps
// frame bytes without check code; last marks the final byte of a frame
interface modbus_link_if;
  logic req_valid;
  logic req_ready;
  logic [7:0] req_data;
  logic req_last;
  logic rsp_valid;
  logic rsp_ready;
  logic [7:0] rsp_data;
  logic rsp_last;

  modport slave (
    input req_valid, req_data, req_last, rsp_ready,
    output req_ready, rsp_valid, rsp_data, rsp_last
  );
  modport master (
    output req_valid, req_data, req_last, rsp_ready,
    input req_ready, rsp_valid, rsp_data, rsp_last
  );
endinterface

// >>> hdl/modbus_slave.sv
`timescale 1ns/1ps
// ----------------
// Summary of operation
// (R1) never execute broadcast holding register reads
// (R2) read request: function, start, count
// (R3) read answer: function, byte count, values
// (R4) float halves stream low register first
// (R5) never execute broadcast single coil writes
// (R6) coil value 0000 off, FF00 on
// (R7) coil request: function, address, state
// (R8) write answers echo the request
// (R9) single register write also executes broadcast
// (R10) register write: function, address, value
// (R11) never execute broadcast multiple coil writes
// (R12) multi coil: start, count, bytes, states
// (R13) states packed per bit, zero padded
// (R14) errors answer function plus 128, code
// (R15) multi-byte fields go high byte first
// (R16) no answer ever to broadcast
// (R17) byte count must equal coils over eight, rounded up
// ----------------
module modbus_slave #(
  parameter int MAX_FRAME = modbus_pkg::MAX_FRAME
) (
  // clock, reset, enable
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // own identifier
  input wire logic [7:0] dev_id_i,
  // link to the master
  modbus_link_if.slave link,
  // holding register read, data is combinational on the address
  output logic [15:0] reg_rd_addr_o,
  input wire logic [15:0] reg_rd_data_i,
  // holding register write strobe
  output logic reg_wr_o,
  output logic [15:0] reg_wr_addr_o,
  output logic [15:0] reg_wr_data_o,
  // contact write strobe
  output logic coil_wr_o,
  output logic [15:0] coil_wr_addr_o,
  output logic coil_wr_val_o
);

  localparam int IW = $clog2(MAX_FRAME);

  typedef enum logic [1:0] {
    ST_RECV = 2'b00,
    ST_DECODE = 2'b01,
    ST_EXEC = 2'b11,
    ST_SEND = 2'b10
  } state_t;

  // ----------------
  // state
  // ----------------
  state_t st_q, st_d;
  modbus_pkg::rsp_kind_t kind_q, kind_d;
  logic [8:0] len_q, len_d;
  logic ovf_q, ovf_d;
  logic [7:0] exc_q, exc_d;
  logic [15:0] idx_q, idx_d;
  logic [8:0] k_q, k_d;
  logic [8:0] tot_q, tot_d;
  logic resp_q, resp_d;
  logic rdy_q, rdy_d;
  logic tv_q, tv_d;
  logic [7:0] td_q, td_d;
  logic tl_q, tl_d;
  logic [15:0] rda_q, rda_d;
  logic wr_q, wr_d;
  logic [15:0] wa_q, wa_d;
  logic [15:0] wd_q, wd_d;
  logic cw_q, cw_d;
  logic [15:0] ca_q, ca_d;
  logic cv_q, cv_d;
  logic mem_we;
  logic [7:0] mem_q [MAX_FRAME];

  // ----------------
  // request fields
  // ----------------
  logic [7:0] fc;
  logic [15:0] fa;
  logic [15:0] fq;
  logic [7:0] fbc;
  logic bcast;
  logic addr_ok;
  logic [8:0] pidx;
  logic [2:0] rem;
  logic pad_bad;
  logic [15:0] cidx;

  assign fc = mem_q[1];
  assign fa = {mem_q[2], mem_q[3]}; // see (R15)
  assign fq = {mem_q[4], mem_q[5]}; // see (R15)
  assign fbc = mem_q[6];
  assign bcast = (mem_q[0] == modbus_pkg::BCAST_ADDR);
  assign addr_ok = bcast || (mem_q[0] == dev_id_i);
  assign pidx = 9'h006 + {1'b0, fbc};
  assign rem = fq[2:0];
  // high bits beyond the last contact must be zero
  assign pad_bad = (rem != 3'h0)
                 && ((mem_q[pidx[IW-1:0]] >> rem) != 8'h00); // see (R13)
  assign cidx = 16'h0007 + (idx_q >> 3);

  // ----------------
  // next state
  // ----------------
  always_comb begin
    logic [7:0] ex;
    logic go;
    logic done;
    logic [8:0] nk;
    ex = 8'h00;
    go = 1'b0;
    done = 1'b0;
    nk = k_q + 9'h001;
    st_d = st_q;
    kind_d = kind_q;
    len_d = len_q;
    ovf_d = ovf_q;
    exc_d = exc_q;
    idx_d = idx_q;
    k_d = k_q;
    tot_d = tot_q;
    resp_d = resp_q;
    rdy_d = rdy_q;
    tv_d = tv_q;
    td_d = td_q;
    tl_d = tl_q;
    rda_d = rda_q;
    wr_d = 1'b0;
    wa_d = wa_q;
    wd_d = wd_q;
    cw_d = 1'b0;
    ca_d = ca_q;
    cv_d = cv_q;
    mem_we = 1'b0;
    case (st_q)
      ST_RECV: begin
        rdy_d = 1'b1;
        if (link.req_valid && rdy_q) begin
          // oversize frames are a length fault and get no answer
          if (len_q < 9'(MAX_FRAME)) begin
            mem_we = 1'b1;
          end else begin
            ovf_d = 1'b1;
          end
          len_d = len_q + 9'h001;
          if (link.req_last) begin
            st_d = ST_DECODE;
            rdy_d = 1'b0;
          end
        end
      end
      ST_DECODE: begin
        st_d = ST_RECV;
        rdy_d = 1'b1;
        len_d = 9'h000;
        ovf_d = 1'b0;
        idx_d = 16'h0000;
        k_d = 9'h000;
        rda_d = fa;
        resp_d = !bcast; // see (R16)
        kind_d = modbus_pkg::K_ECHO; // see (R8)
        tot_d = len_q;
        if (addr_ok && !ovf_q && len_q >= 9'h002) begin
          case (fc)
            modbus_pkg::FC_RD_HOLD: begin
              if (len_q == modbus_pkg::SHORT_FRAME_LEN && !bcast) begin // see (R1) (R2)
                if (fq == 16'h0000 || fq > modbus_pkg::MAX_READ_REGS) begin
                  ex = modbus_pkg::EXC_ILL_VAL;
                end else begin
                  kind_d = modbus_pkg::K_READ;
                  tot_d = 9'h003 + {fq[7:0], 1'b0}; // see (R3)
                  go = 1'b1;
                end
              end
            end
            modbus_pkg::FC_WR_COIL: begin
              if (len_q == modbus_pkg::SHORT_FRAME_LEN && !bcast) begin // see (R5) (R7)
                if (fq != modbus_pkg::COIL_OFF
                    && fq != modbus_pkg::COIL_ON) begin // see (R6)
                  ex = modbus_pkg::EXC_ILL_VAL;
                end else begin
                  st_d = ST_EXEC;
                  rdy_d = 1'b0;
                end
              end
            end
            modbus_pkg::FC_WR_REG: begin
              if (len_q == modbus_pkg::SHORT_FRAME_LEN) begin // see (R9) (R10)
                st_d = ST_EXEC;
                rdy_d = 1'b0;
              end
            end
            modbus_pkg::FC_WR_COILS: begin
              if (len_q >= modbus_pkg::COILS_HDR_LEN
                  && len_q == modbus_pkg::COILS_HDR_LEN + {1'b0, fbc}
                  && !bcast) begin // see (R11) (R12)
                if (fq == 16'h0000
                    || {8'h00, fbc} != modbus_pkg::coil_bytes(fq)
                    || pad_bad) begin // see (R17) (R13)
                  ex = modbus_pkg::EXC_ILL_VAL;
                end else begin
                  st_d = ST_EXEC;
                  rdy_d = 1'b0;
                end
              end
            end
            default: begin
              if (!bcast) begin
                ex = modbus_pkg::EXC_ILL_FUNC;
              end
            end
          endcase
        end
        if (ex != 8'h00) begin
          kind_d = modbus_pkg::K_EXC; // see (R14)
          exc_d = ex;
          tot_d = 9'h003;
          go = 1'b1;
        end
      end
      ST_EXEC: begin
        case (fc)
          modbus_pkg::FC_WR_COIL: begin
            cw_d = 1'b1;
            ca_d = fa;
            cv_d = (fq == modbus_pkg::COIL_ON); // see (R6)
            done = 1'b1;
          end
          modbus_pkg::FC_WR_REG: begin
            wr_d = 1'b1;
            wa_d = fa;
            wd_d = fq;
            done = 1'b1;
          end
          default: begin
            // one contact per cycle, lowest bit of each byte first
            cw_d = 1'b1;
            ca_d = fa + idx_q;
            cv_d = mem_q[cidx[IW-1:0]][idx_q[2:0]]; // see (R13)
            idx_d = idx_q + 16'h0001;
            done = (idx_d == fq);
          end
        endcase
        if (done) begin
          if (resp_q) begin
            go = 1'b1;
          end else begin
            st_d = ST_RECV; // see (R16)
            rdy_d = 1'b1;
          end
        end
      end
      ST_SEND: begin
        if (tv_q && link.rsp_ready) begin
          if (tl_q) begin
            tv_d = 1'b0;
            tl_d = 1'b0;
            st_d = ST_RECV;
            rdy_d = 1'b1;
          end else begin
            k_d = nk;
            tl_d = (nk == tot_q - 9'h001);
            case (kind_q)
              modbus_pkg::K_EXC: begin
                td_d = (nk == 9'h001) ? (fc | modbus_pkg::EXC_FLAG)
                                      : exc_q; // see (R14)
              end
              modbus_pkg::K_READ: begin
                if (nk == 9'h001) begin
                  td_d = fc;
                end else if (nk == 9'h002) begin
                  td_d = {fq[6:0], 1'b0}; // see (R3)
                end else if (!nk[0]) begin
                  td_d = reg_rd_data_i[7:0];
                  rda_d = rda_q + 16'h0001; // see (R4)
                end else begin
                  td_d = reg_rd_data_i[15:8]; // see (R15)
                end
              end
              default: begin
                td_d = mem_q[nk[IW-1:0]]; // see (R8)
              end
            endcase
          end
        end
      end
      default: begin
        st_d = ST_RECV;
        rdy_d = 1'b1;
      end
    endcase
    if (go) begin
      st_d = ST_SEND;
      rdy_d = 1'b0;
      tv_d = 1'b1;
      td_d = dev_id_i;
      tl_d = 1'b0;
    end
  end

  // ----------------
  // registers
  // ----------------
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_q <= ST_RECV;
      kind_q <= modbus_pkg::K_ECHO;
      len_q <= 9'h000;
      ovf_q <= 1'b0;
      exc_q <= 8'h00;
      idx_q <= 16'h0000;
      k_q <= 9'h000;
      tot_q <= 9'h000;
      resp_q <= 1'b0;
      rdy_q <= 1'b0;
      tv_q <= 1'b0;
      td_q <= 8'h00;
      tl_q <= 1'b0;
      rda_q <= 16'h0000;
      wr_q <= 1'b0;
      wa_q <= 16'h0000;
      wd_q <= 16'h0000;
      cw_q <= 1'b0;
      ca_q <= 16'h0000;
      cv_q <= 1'b0;
    end else if (ce_i) begin
      st_q <= st_d;
      kind_q <= kind_d;
      len_q <= len_d;
      ovf_q <= ovf_d;
      exc_q <= exc_d;
      idx_q <= idx_d;
      k_q <= k_d;
      tot_q <= tot_d;
      resp_q <= resp_d;
      rdy_q <= rdy_d;
      tv_q <= tv_d;
      td_q <= td_d;
      tl_q <= tl_d;
      rda_q <= rda_d;
      wr_q <= wr_d;
      wa_q <= wa_d;
      wd_q <= wd_d;
      cw_q <= cw_d;
      ca_q <= ca_d;
      cv_q <= cv_d;
    end
  end

  // frame store is not reset; only bytes of the current frame are read
  always_ff @(posedge core_clk_i) begin
    if (ce_i && mem_we) begin
      mem_q[len_q[IW-1:0]] <= link.req_data;
    end
  end

  assign link.req_ready = rdy_q;
  assign link.rsp_valid = tv_q;
  assign link.rsp_data = td_q;
  assign link.rsp_last = tl_q;
  assign reg_rd_addr_o = rda_q;
  assign reg_wr_o = wr_q;
  assign reg_wr_addr_o = wa_q;
  assign reg_wr_data_o = wd_q;
  assign coil_wr_o = cw_q;
  assign coil_wr_addr_o = ca_q;
  assign coil_wr_val_o = cv_q;

endmodule

// >>> hdl/modbus_master.sv
`timescale 1ns/1ps
module modbus_master #(
  parameter int MAX_COILS = 64
) (
  // clock, reset, enable
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // command
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic [7:0] cmd_slave_i,
  input wire logic [7:0] cmd_func_i,
  input wire logic [15:0] cmd_addr_i,
  input wire logic [15:0] cmd_qty_i,
  input wire logic [15:0] cmd_value_i,
  input wire logic cmd_coil_on_i,
  input wire logic [MAX_COILS-1:0] cmd_coils_i,
  // answer bytes and completion
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_last_o,
  output logic done_o,
  output logic timeout_o,
  // link to the slave
  modbus_link_if.master link
);

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_SEND = 2'b01,
    H_WAIT = 2'b11
  } state_t;

  state_t st_q, st_d;
  logic crdy_q, crdy_d;
  logic [7:0] sl_q, sl_d;
  logic [7:0] fc_q, fc_d;
  logic [15:0] a_q, a_d;
  logic [15:0] f_q, f_d;
  logic [15:0] qty_q, qty_d;
  logic [7:0] bc_q, bc_d;
  logic [MAX_COILS-1:0] cl_q, cl_d;
  logic [8:0] k_q, k_d;
  logic [8:0] tot_q, tot_d;
  logic tv_q, tv_d;
  logic [7:0] td_q, td_d;
  logic tl_q, tl_d;
  logic prdy_q, prdy_d;
  logic [15:0] tmr_q, tmr_d;
  logic rxv_q, rxv_d;
  logic [7:0] rxd_q, rxd_d;
  logic rxl_q, rxl_d;
  logic done_q, done_d;
  logic to_q, to_d;

  // ----------------
  // packed contact byte j, unused high bits forced to zero
  // ----------------
  function automatic logic [7:0] pack(input logic [8:0] j);
    logic [7:0] p;
    int i;
    p = 8'h00;
    for (int b = 0; b < 8; b++) begin
      i = int'(j) * 8 + b;
      if (i < int'(qty_q) && i < MAX_COILS) begin
        p[b] = cl_q[i];
      end
    end
    return p;
  endfunction

  always_comb begin
    logic [8:0] nk;
    logic [15:0] nb;
    nk = k_q + 9'h001;
    nb = modbus_pkg::coil_bytes(cmd_qty_i);
    st_d = st_q;
    crdy_d = crdy_q;
    sl_d = sl_q;
    fc_d = fc_q;
    a_d = a_q;
    f_d = f_q;
    qty_d = qty_q;
    bc_d = bc_q;
    cl_d = cl_q;
    k_d = k_q;
    tot_d = tot_q;
    tv_d = tv_q;
    td_d = td_q;
    tl_d = tl_q;
    prdy_d = prdy_q;
    tmr_d = tmr_q;
    rxv_d = 1'b0;
    rxd_d = rxd_q;
    rxl_d = rxl_q;
    done_d = 1'b0;
    to_d = 1'b0;
    case (st_q)
      H_IDLE: begin
        crdy_d = 1'b1;
        if (cmd_valid_i && crdy_q) begin
          crdy_d = 1'b0;
          sl_d = cmd_slave_i;
          fc_d = cmd_func_i;
          a_d = cmd_addr_i;
          qty_d = cmd_qty_i;
          bc_d = nb[7:0];
          cl_d = cmd_coils_i;
          case (cmd_func_i)
            modbus_pkg::FC_WR_COIL: f_d = cmd_coil_on_i ? modbus_pkg::COIL_ON
                                                     : modbus_pkg::COIL_OFF;
            modbus_pkg::FC_WR_REG: f_d = cmd_value_i;
            default: f_d = cmd_qty_i;
          endcase
          tot_d = (cmd_func_i == modbus_pkg::FC_WR_COILS)
                ? modbus_pkg::COILS_HDR_LEN + {1'b0, nb[7:0]}
                : modbus_pkg::SHORT_FRAME_LEN;
          k_d = 9'h000;
          tv_d = 1'b1;
          td_d = cmd_slave_i;
          tl_d = 1'b0;
          st_d = H_SEND;
        end
      end
      H_SEND: begin
        if (tv_q && link.req_ready) begin
          if (tl_q) begin
            tv_d = 1'b0;
            tl_d = 1'b0;
            tmr_d = 16'h0000;
            if (sl_q == modbus_pkg::BCAST_ADDR) begin
              // a broadcast never gets an answer
              done_d = 1'b1;
              st_d = H_IDLE;
              crdy_d = 1'b1;
            end else begin
              prdy_d = 1'b1;
              st_d = H_WAIT;
            end
          end else begin
            k_d = nk;
            tl_d = (nk == tot_q - 9'h001);
            case (nk)
              9'h001: td_d = fc_q;
              9'h002: td_d = a_q[15:8];
              9'h003: td_d = a_q[7:0];
              9'h004: td_d = f_q[15:8];
              9'h005: td_d = f_q[7:0];
              9'h006: td_d = bc_q;
              default: td_d = pack(nk - modbus_pkg::COILS_HDR_LEN);
            endcase
          end
        end
      end
      H_WAIT: begin
        tmr_d = tmr_q + 16'h0001;
        if (link.rsp_valid && prdy_q) begin
          rxv_d = 1'b1;
          rxd_d = link.rsp_data;
          rxl_d = link.rsp_last;
          if (link.rsp_last) begin
            done_d = 1'b1;
            prdy_d = 1'b0;
            st_d = H_IDLE;
          end
        end else if (tmr_q == 16'(modbus_pkg::RESP_TIMEOUT_CYC - 1)) begin
          to_d = 1'b1;
          prdy_d = 1'b0;
          st_d = H_IDLE;
        end
      end
      default: begin
        st_d = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_q <= H_IDLE;
      crdy_q <= 1'b0;
      sl_q <= 8'h00;
      fc_q <= 8'h00;
      a_q <= 16'h0000;
      f_q <= 16'h0000;
      qty_q <= 16'h0000;
      bc_q <= 8'h00;
      cl_q <= '0;
      k_q <= 9'h000;
      tot_q <= 9'h000;
      tv_q <= 1'b0;
      td_q <= 8'h00;
      tl_q <= 1'b0;
      prdy_q <= 1'b0;
      tmr_q <= 16'h0000;
      rxv_q <= 1'b0;
      rxd_q <= 8'h00;
      rxl_q <= 1'b0;
      done_q <= 1'b0;
      to_q <= 1'b0;
    end else if (ce_i) begin
      st_q <= st_d;
      crdy_q <= crdy_d;
      sl_q <= sl_d;
      fc_q <= fc_d;
      a_q <= a_d;
      f_q <= f_d;
      qty_q <= qty_d;
      bc_q <= bc_d;
      cl_q <= cl_d;
      k_q <= k_d;
      tot_q <= tot_d;
      tv_q <= tv_d;
      td_q <= td_d;
      tl_q <= tl_d;
      prdy_q <= prdy_d;
      tmr_q <= tmr_d;
      rxv_q <= rxv_d;
      rxd_q <= rxd_d;
      rxl_q <= rxl_d;
      done_q <= done_d;
      to_q <= to_d;
    end
  end

  assign cmd_ready_o = crdy_q;
  assign rx_valid_o = rxv_q;
  assign rx_data_o = rxd_q;
  assign rx_last_o = rxl_q;
  assign done_o = done_q;
  assign timeout_o = to_q;
  assign link.req_valid = tv_q;
  assign link.req_data = td_q;
  assign link.req_last = tl_q;
  assign link.rsp_ready = prdy_q;

endmodule

// >>> bench/modbus_link_asserts.sv
`timescale 1ns/1ps
module modbus_link_asserts (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // request direction
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [7:0] req_data,
  input wire logic req_last,
  // answer direction
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_last
);
  // ----------------
  // frame trackers
  // ----------------
  logic [8:0] req_n_q;
  logic [8:0] rsp_n_q;
  logic [7:0] id_q;
  logic [7:0] fc_q;
  logic [7:0] ql_q;
  logic bc_q;
  logic exc_q;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      req_n_q <= 9'h000;
      rsp_n_q <= 9'h000;
      bc_q <= 1'b0;
      exc_q <= 1'b0;
    end else begin
      if (req_valid && req_ready) begin
        req_n_q <= req_last ? 9'h000 : req_n_q + 9'h001;
        if (req_n_q == 9'h000) begin
          id_q <= req_data;
          bc_q <= (req_data == 8'h00);
        end
        if (req_n_q == 9'h001) fc_q <= req_data;
        if (req_n_q == 9'h005) ql_q <= req_data;
      end
      if (rsp_valid && rsp_ready) begin
        rsp_n_q <= rsp_last ? 9'h000 : rsp_n_q + 9'h001;
        if (rsp_n_q == 9'h001) exc_q <= rsp_data[7];
      end
    end
  end

  // ----------------
  // properties
  // ----------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_req_held: assert property (req_valid && !req_ready |=> req_valid &&
    $stable(req_data) && $stable(req_last))
    else $error("request byte not held");
  a_rsp_held: assert property (rsp_valid && !rsp_ready |=> rsp_valid &&
    $stable(rsp_data) && $stable(rsp_last))
    else $error("answer byte not held");
  a_bcast_silent: assert property (bc_q |-> !rsp_valid)
    else $error("broadcast answered");
  a_id_echo: assert property (rsp_valid && rsp_n_q == 9'h000 |->
    rsp_data == id_q)
    else $error("answer address wrong");
  a_fc_echo: assert property (rsp_valid && rsp_n_q == 9'h001 |->
    rsp_data == fc_q || rsp_data == (fc_q | 8'h80))
    else $error("answer function wrong");
  a_read_count: assert property (rsp_valid && rsp_n_q == 9'h002 &&
    fc_q == 8'h03 && !exc_q |-> rsp_data == {ql_q[6:0], 1'b0})
    else $error("read byte count wrong");
  a_exc_frame: assert property (rsp_valid && rsp_n_q == 9'h002 && exc_q
    |-> rsp_data inside {[8'h01:8'h04]} && rsp_last)
    else $error("exception frame bad");
  a_rsp_prompt: assert property (req_valid && req_ready && req_last |->
    ##[1:300] (rsp_valid || req_ready))
    else $error("slave stuck");
  a_one_frame: assert property (rsp_valid |-> !req_ready)
    else $error("request taken while answering");

  c_exc: cover property (rsp_valid && rsp_n_q == 9'h002 && exc_q);
  c_read: cover property (rsp_valid && rsp_n_q == 9'h002 && !exc_q);
  c_bcast: cover property (bc_q && req_ready);
endmodule

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  localparam logic [7:0] OWN_ID = 8'h05;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_coil_on = 1'b0;
  logic [7:0] cmd_slave = 8'h00;
  logic [7:0] cmd_func = 8'h00;
  logic [15:0] cmd_addr = 16'h0000;
  logic [15:0] cmd_qty = 16'h0000;
  logic [15:0] cmd_value = 16'h0000;
  logic [63:0] cmd_coils = 64'h0;
  logic cmd_ready, rx_valid, rx_last, done, tmo, wr_stb, coil_stb, coil_val;
  logic [7:0] rx_data;
  logic [15:0] rd_addr, wr_addr, wr_data, coil_addr;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [7:0] exp_q[$];
  logic [7:0] got_q[$];
  logic [33:0] exp_w[$];
  logic [33:0] got_w[$];

  always #5 core_clk = ~core_clk;

  modbus_link_if link_bus ();
  modbus_master modbus_master_inst (.core_clk_i(core_clk),
    .sys_rst_i(sys_rst), .ce_i(1'b1), .cmd_valid_i(cmd_valid),
    .cmd_ready_o(cmd_ready), .cmd_slave_i(cmd_slave), .cmd_func_i(cmd_func),
    .cmd_addr_i(cmd_addr), .cmd_qty_i(cmd_qty), .cmd_value_i(cmd_value),
    .cmd_coil_on_i(cmd_coil_on), .cmd_coils_i(cmd_coils),
    .rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_last_o(rx_last),
    .done_o(done), .timeout_o(tmo), .link(link_bus));
  modbus_slave modbus_slave_inst (.core_clk_i(core_clk), .sys_rst_i(sys_rst),
    .ce_i(1'b1), .dev_id_i(OWN_ID), .link(link_bus),
    .reg_rd_addr_o(rd_addr), .reg_rd_data_i(rd_addr ^ 16'h5AC3),
    .reg_wr_o(wr_stb), .reg_wr_addr_o(wr_addr), .reg_wr_data_o(wr_data),
    .coil_wr_o(coil_stb), .coil_wr_addr_o(coil_addr),
    .coil_wr_val_o(coil_val));
  modbus_link_asserts modbus_link_asserts_inst (.core_clk_i(core_clk),
    .sys_rst_i(sys_rst), .req_valid(link_bus.req_valid),
    .req_ready(link_bus.req_ready), .req_data(link_bus.req_data),
    .req_last(link_bus.req_last), .rsp_valid(link_bus.rsp_valid),
    .rsp_ready(link_bus.rsp_ready), .rsp_data(link_bus.rsp_data),
    .rsp_last(link_bus.rsp_last));

  // ----------------
  // monitors and watchdog
  // ----------------
  always @(posedge core_clk) begin
    cyc++;
    if (rx_valid) got_q.push_back(rx_data);
    if (wr_stb) got_w.push_back({2'b01, wr_addr, wr_data});
    if (coil_stb) got_w.push_back({2'b10, coil_addr, 15'h0000, coil_val});
    if (cyc == 60000) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (n_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------
  // reference model, one command at a time
  // ----------------
  task automatic go(input logic [7:0] sl, input logic [7:0] fc,
    input logic [15:0] ad, input logic [15:0] qt, input logic [15:0] va,
    input logic on, input logic [63:0] co);
    logic [15:0] f;
    logic [15:0] v;
    logic [63:0] m;
    int nb;
    int n;
    exp_q.delete();
    exp_w.delete();
    got_q.delete();
    got_w.delete();
    f = (fc == 8'h05) ? (on ? 16'hFF00 : 16'h0000) :
      (fc == 8'h03 || fc == 8'h0F) ? qt : va;
    m = co & ((64'h1 << qt) - 64'h1);
    nb = (qt + 7) / 8;
    if (sl == OWN_ID || sl == 8'h00) begin
      if (fc == 8'h06) exp_w.push_back({2'b01, ad, va});
      if (fc == 8'h05 && sl != 8'h00) exp_w.push_back({2'b10, ad, 15'h0, on});
      if (fc == 8'h0F && sl != 8'h00 && qt != 16'h0) begin
        for (int i = 0; i < qt; i++) begin
          exp_w.push_back({2'b10, ad + 16'(i), 15'h0, co[i]});
        end
      end
    end
    // broadcast and foreign addresses get no answer at all
    if (sl == OWN_ID) begin
      exp_q = {sl};
      if (!(fc inside {8'h03, 8'h05, 8'h06, 8'h0F})) begin
        exp_q.push_back(fc | 8'h80);
        exp_q.push_back(8'h01);
      end else if ((fc == 8'h03 && (qt == 16'h0 || qt > 16'h0032)) ||
        (fc == 8'h0F && qt == 16'h0)) begin
        exp_q.push_back(fc | 8'h80);
        exp_q.push_back(8'h03);
      end else if (fc == 8'h03) begin
        exp_q.push_back(fc);
        exp_q.push_back(8'(qt * 2));
        for (int i = 0; i < qt; i++) begin
          v = (ad + 16'(i)) ^ 16'h5AC3;
          exp_q.push_back(v[15:8]);
          exp_q.push_back(v[7:0]);
        end
      end else begin
        exp_q = {sl, fc, ad[15:8], ad[7:0], f[15:8], f[7:0]};
        if (fc == 8'h0F) begin
          exp_q.push_back(8'(nb));
          for (int j = 0; j < nb; j++) exp_q.push_back(m[8*j+:8]);
        end
      end
    end
    // drive the command and hold it until it is taken
    @(posedge core_clk);
    #1;
    {cmd_slave, cmd_func, cmd_addr, cmd_qty, cmd_value} = {sl, fc, ad, qt, va};
    cmd_coil_on = on;
    cmd_coils = co;
    cmd_valid = 1'b1;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && tmo !== 1'b1 && n < 1500) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    repeat (3) @(posedge core_clk);
    #1;
    n = 0;
    while (!(link_bus.req_ready === 1'b1 && cmd_ready === 1'b1) && n < 200)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    `CHK(got_q.size(), exp_q.size())
    `CHK(got_w.size(), exp_w.size())
    foreach (exp_q[i])
      if (i < got_q.size()) `CHK(got_q[i], exp_q[i])
    foreach (exp_w[i])
      if (i < got_w.size()) `CHK(got_w[i], exp_w[i])
  endtask

  // ----------------
  // scenarios
  // ----------------
  initial begin
    logic [15:0] q;
    void'($urandom(73));
    repeat (3) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    repeat (2) @(posedge core_clk);
    go(OWN_ID, 8'h03, 16'h0004, 16'h0003, 16'h0, 1'b0, 64'h0);
    go(OWN_ID, 8'h03, 16'($urandom), 16'h0032, 16'h0, 1'b0,
      64'h0);
    go(OWN_ID, 8'h03, 16'h0010, 16'h0033, 16'h0, 1'b0, 64'h0);
    go(OWN_ID, 8'h03, 16'h0010, 16'h0000, 16'h0, 1'b0, 64'h0);
    go(8'h00, 8'h03, 16'h0004, 16'h0002, 16'h0, 1'b0, 64'h0);
    for (int k = 0; k < 2; k++) begin
      go(OWN_ID, 8'h05, 16'($urandom), 16'h0, 16'h0, k[0],
        64'h0);
      go(8'h00, 8'h05, 16'h0076, 16'h0, 16'h0, k[0],
        64'h0);
    end
    for (int k = 0; k < 4; k++) begin
      go(OWN_ID, 8'h06, 16'($urandom), 16'h0, 16'($urandom), 1'b0,
        64'h0);
      go(8'h00, 8'h06, 16'($urandom), 16'h0, 16'($urandom), 1'b0,
        64'h0);
    end
    for (int k = 0; k < 5; k++) begin
      q = (k == 0) ? 16'h0008 : 16'(1 + $urandom % 20);
      go(OWN_ID, 8'h0F, 16'($urandom), q, 16'h0, 1'b0,
        {$urandom, $urandom});
    end
    go(8'h00, 8'h0F, 16'h0076, 16'h0003, 16'h0, 1'b0, 64'hFF);
    go(OWN_ID, 8'h0F, 16'h0076, 16'h0000, 16'h0, 1'b0, 64'h0);
    go(OWN_ID, 8'h11, 16'h0001, 16'h0001, 16'h0, 1'b0, 64'h0);
    go(8'h07, 8'h06, 16'h000A, 16'h0, 16'h0003, 1'b0, 64'h0);
    give_verdict();
  end
endmodule
